// ==== include/otc_pkg.sv ====
// Purpose: Shared constants and types for the test and calibration control block
// Assumes: Byte addresses are those of the management page that holds the register
// Notes: Reserved bits are never stored, so they always read back as zero
package otc_pkg;
  // Register location and reset value
  localparam logic [7:0] OTC_TEST_CAL_ADDR = 8'h10;
  localparam logic [7:0] OTC_TEST_CAL_RESET = 8'h00;
  // Writable bits; reserved positions are dropped on write
  localparam logic [7:0] OTC_TEST_CAL_WMASK = 8'h79;
  // Field positions inside the control register
  localparam int OTC_FAULT_COMPARE_DISABLE_BIT = 6;
  localparam int OTC_FAULT_CHANNEL_HOLD_BIT = 5;
  localparam int OTC_NV_WRITE_INHIBIT_BIT = 4;
  localparam int OTC_DAC_DIRECT_MODE_BIT = 3;
  localparam int OTC_FORCE_OUTPUTS_TEST_BIT = 0;
  // Widths
  localparam int OTC_DAC_W = 8;
  localparam int OTC_NUM_CH = 3;
  // Channel select code that names no comparator channel
  localparam logic [1:0] OTC_SEL_NONE = 2'h3;
  // Synchroniser depth for the external loss pin
  localparam int OTC_SYNC_DEPTH = 3;
  // Fault comparator channels, visited in this order
  typedef enum logic [1:0] {
    OTC_CH_BIAS,
    OTC_CH_TX_POWER,
    OTC_CH_RX_POWER
  } otc_chan_e;
endpackage

// ==== include/otc_cmp_if.sv ====
// Purpose: Link between the control register logic and the fault comparator
// Assumes: Both ends run on the same clock
// Notes: Flags are sticky in the comparator and cleared by a one-cycle pulse
interface otc_cmp_if;
  logic run;
  logic hold;
  logic [1:0] sel;
  logic [otc_pkg::OTC_NUM_CH-1:0] cond;
  logic [otc_pkg::OTC_NUM_CH-1:0] clr;
  logic [otc_pkg::OTC_NUM_CH-1:0] flags;
  otc_pkg::otc_chan_e chan;
  modport ctrl (output run, output hold, output sel, output cond, output clr, input flags, input chan);
  modport cmp (input run, input hold, input sel, input cond, input clr, output flags, output chan);
endinterface

// ==== verilog/otc_fault_cmp.sv ====
// Purpose: Scanning fault comparator with sticky fault flags
// Assumes: Raw over/under conditions come from same-clock logic
// Notes: One channel is examined per clock; bit order is bias, tx power, rx power
module otc_fault_cmp (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control side
  otc_cmp_if.cmp bus
);
  import otc_pkg::*;

  typedef struct packed {
    otc_chan_e chan;
    logic [OTC_NUM_CH-1:0] flags;
  } otc_cmp_s;

  otc_cmp_s s_q, s_d;
  logic [1:0] exam;
  logic exam_ok;

  assign bus.flags = s_q.flags;
  assign bus.chan = s_q.chan;

  // Channel under test: held channel or the scanning one
  always_comb begin
    exam = bus.hold ? bus.sel : 2'(s_q.chan);
    exam_ok = bus.run && !(bus.hold && bus.sel == OTC_SEL_NONE);
  end

  // Scan, detect and latch; a set in the clear cycle wins
  always_comb begin
    s_d = s_q;
    if (bus.run && !bus.hold) begin
      s_d.chan = (s_q.chan == OTC_CH_RX_POWER) ? OTC_CH_BIAS : otc_chan_e'(2'(s_q.chan) + 2'h1);
    end
    s_d.flags = s_q.flags & ~bus.clr;
    if (exam_ok && bus.cond[exam]) begin
      s_d.flags[exam] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_q <= '{chan: OTC_CH_BIAS, flags: '0};
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_stopped_no_set: assert property (!bus.run |=> (s_q.flags & ~$past(s_q.flags)) == '0)
    else $error("fault flag set while comparator stopped");
  chk_flag_sticky: assert property ((|s_q.flags) && bus.clr == '0 |=>
    (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
    else $error("fault flag lost without clear");
  chk_hold_other_quiet: assert property (bus.run && bus.hold && bus.sel != OTC_SEL_NONE
    && bus.cond[bus.sel] == 1'b0 |=> s_q.flags == ($past(s_q.flags) & ~$past(bus.clr)))
    else $error("unexamined channel responded");
  chk_hold_detect: assert property (bus.run && bus.hold && bus.sel == 2'h1 && bus.cond[1] |=> s_q.flags[1])
    else $error("held channel fault not latched");
  chk_scan_wraps: assert property (bus.run && !bus.hold && s_q.chan == OTC_CH_RX_POWER |=>
    s_q.chan == OTC_CH_BIAS)
    else $error("scan order broken");
endmodule

// ==== verilog/otc_ctrl.sv ====
// Purpose: Test and calibration control register with its output overrides
// Assumes: Serial engine presents decoded byte reads and writes on this clock
// Notes: Every output is registered, so a control change shows one clock later, and two later on the fault flags
// How it works
// - Disable bit set stops the fault comparator; clear lets it run.
// - Stopped comparator detects no bias, transmit power or receive power faults.
// - Already latched flags stay until cleared and do not set while stopped.
// - Channel hold bit makes the comparator examine one channel only.
// - Held channel comes from ADC control select; other channels ignore faults.
// - Write inhibit bit suppresses every nonvolatile programming cycle.
// - Inhibited writes still update working values but not backing storage.
// - Direct mode bypasses lookup tables; DACs take their register values.
// - Force bit drives transmit fault, interrupt and receive loss active.
// - Forced levels follow polarity configuration; receive loss source does not matter.
// - Forced interrupt only goes active while the OEM mask is clear.
// - Register clears at power-up; access needs a valid OEM password.
// - Interrupt asserts only with global enable high and OEM mask low.
module otc_ctrl (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register access from the serial engine
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic oem_pw_valid_in,
  output logic [7:0] reg_rdata_out,
  // Configuration from neighbouring registers
  input wire logic [1:0] adc_spin_sel_in,
  input wire logic oem_interrupt_mask_in,
  input wire logic global_interrupt_enable_in,
  input wire logic tx_fault_active_high_in,
  input wire logic rx_loss_active_high_in,
  input wire logic rx_loss_from_pin_in,
  // Fault sources and events
  input wire logic [otc_pkg::OTC_NUM_CH-1:0] fault_cond_in,
  input wire logic [otc_pkg::OTC_NUM_CH-1:0] fault_clear_in,
  input wire logic int_event_in,
  input wire logic rx_loss_pin_in,
  // Nonvolatile write path
  input wire logic nv_wr_req_in,
  output logic nv_working_wr_out,
  output logic nv_program_out,
  // Laser DAC values
  input wire logic [otc_pkg::OTC_DAC_W-1:0] bias_dac_reg_in,
  input wire logic [otc_pkg::OTC_DAC_W-1:0] bias_dac_table_in,
  input wire logic [otc_pkg::OTC_DAC_W-1:0] mod_dac_reg_in,
  input wire logic [otc_pkg::OTC_DAC_W-1:0] mod_dac_table_in,
  output logic [otc_pkg::OTC_DAC_W-1:0] bias_dac_out,
  output logic [otc_pkg::OTC_DAC_W-1:0] mod_dac_out,
  // Module outputs and status
  output logic transmit_fault_output_out,
  output logic interrupt_n_out,
  output logic receive_loss_output_out,
  output logic [otc_pkg::OTC_NUM_CH-1:0] fault_flags_out,
  output logic [7:0] test_cal_out
);
  import otc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic [OTC_SYNC_DEPTH-1:0] los_sync;
    logic los_pin;
    logic txf;
    logic int_n;
    logic receive_loss_output;
    logic nv_work;
    logic nv_prog;
    logic [OTC_DAC_W-1:0] bias_dac;
    logic [OTC_DAC_W-1:0] mod_dac;
    logic [OTC_NUM_CH-1:0] flags;
  } otc_state_s;

  localparam otc_state_s OTC_STATE_RESET = '{
    ctrl: OTC_TEST_CAL_RESET, rdata: 8'h00, los_sync: '0, los_pin: 1'b0, txf: 1'b0,
    int_n: 1'b1, receive_loss_output: 1'b0, nv_work: 1'b0, nv_prog: 1'b0, bias_dac: '0, mod_dac: '0, flags: '0};

  otc_state_s s_q, s_d;
  otc_cmp_if cmp_bus ();

  // Turn an active condition into a pin level of the chosen polarity
  function automatic logic otc_level(input logic active, input logic active_high);
    return active_high ? active : ~active;
  endfunction

  // Register hit only with a valid password
  function automatic logic otc_hit(input logic strobe, input logic [7:0] addr, input logic pw_ok);
    return strobe && pw_ok && addr == OTC_TEST_CAL_ADDR;
  endfunction

  // Run and hold come straight from the stored register; select, conditions and clears from inputs
  assign cmp_bus.run = ~s_q.ctrl[OTC_FAULT_COMPARE_DISABLE_BIT];
  assign cmp_bus.hold = s_q.ctrl[OTC_FAULT_CHANNEL_HOLD_BIT];
  assign cmp_bus.sel = adc_spin_sel_in;
  assign cmp_bus.cond = fault_cond_in;
  assign cmp_bus.clr = fault_clear_in;

  otc_fault_cmp u_cmp (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .bus(cmp_bus.cmp)
  );

  // Next state: register access, pin sync and output overrides
  always_comb begin
    logic force_on;
    logic txf_act;
    logic int_act;
    logic los_act;
    force_on = 1'b0;
    txf_act = 1'b0;
    int_act = 1'b0;
    los_act = 1'b0;
    s_d = s_q;
    // Reserved bits are not stored, so stray ones written there cannot leak
    if (otc_hit(reg_wr_in, reg_addr_in, oem_pw_valid_in)) begin
      s_d.ctrl = reg_wdata_in & OTC_TEST_CAL_WMASK;
    end
    s_d.rdata = otc_hit(reg_rd_in, reg_addr_in, oem_pw_valid_in) ? s_q.ctrl : 8'h00;
    // Three-stage sync; a change counts once the last two stages agree
    s_d.los_sync = {s_q.los_sync[OTC_SYNC_DEPTH-2:0], rx_loss_pin_in};
    if (s_q.los_sync[1] == s_q.los_sync[2]) begin
      s_d.los_pin = s_q.los_sync[2];
    end
    force_on = s_q.ctrl[OTC_FORCE_OUTPUTS_TEST_BIT];
    txf_act = force_on | (|cmp_bus.flags);
    s_d.txf = otc_level(txf_act, tx_fault_active_high_in);
    // Both gates apply even in test, so a masked part never pulls the shared line
    int_act = global_interrupt_enable_in & ~oem_interrupt_mask_in & (force_on | int_event_in);
    s_d.int_n = ~int_act;
    los_act = force_on | (rx_loss_from_pin_in ? s_q.los_pin : cmp_bus.flags[OTC_CH_RX_POWER]);
    s_d.receive_loss_output = otc_level(los_act, rx_loss_active_high_in);
    s_d.nv_work = nv_wr_req_in;
    s_d.nv_prog = nv_wr_req_in & ~s_q.ctrl[OTC_NV_WRITE_INHIBIT_BIT];
    if (s_q.ctrl[OTC_DAC_DIRECT_MODE_BIT]) begin
      s_d.bias_dac = bias_dac_reg_in;
      s_d.mod_dac = mod_dac_reg_in;
    end else begin
      s_d.bias_dac = bias_dac_table_in;
      s_d.mod_dac = mod_dac_table_in;
    end
    s_d.flags = cmp_bus.flags;
  end

  // State register; reset loads the power-up image
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_q <= OTC_STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out = s_q.rdata;
  assign nv_working_wr_out = s_q.nv_work;
  assign nv_program_out = s_q.nv_prog;
  assign bias_dac_out = s_q.bias_dac;
  assign mod_dac_out = s_q.mod_dac;
  assign transmit_fault_output_out = s_q.txf;
  assign interrupt_n_out = s_q.int_n;
  assign receive_loss_output_out = s_q.receive_loss_output;
  assign fault_flags_out = s_q.flags;
  assign test_cal_out = s_q.ctrl;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_valid_write;
    reg_wr_in && oem_pw_valid_in && reg_addr_in == OTC_TEST_CAL_ADDR;
  endsequence
  sequence s_force_clear_write;
    s_valid_write ##0 !reg_wdata_in[OTC_FORCE_OUTPUTS_TEST_BIT];
  endsequence
  sequence s_valid_read;
    reg_rd_in && oem_pw_valid_in && reg_addr_in == OTC_TEST_CAL_ADDR;
  endsequence

  chk_reset_image: assert property ($fell(rst_in) |-> s_q.ctrl == OTC_TEST_CAL_RESET)
    else $error("control register not clear after reset");
  chk_pw_gate: assert property (reg_wr_in && !oem_pw_valid_in |=> s_q.ctrl == $past(s_q.ctrl))
    else $error("write taken without password");
  chk_write_takes: assert property (s_valid_write |=> s_q.ctrl == ($past(reg_wdata_in) & OTC_TEST_CAL_WMASK))
    else $error("control write not stored");
  // With no live request the interrupt must drop as soon as the force bit goes
  chk_force_release: assert property (s_force_clear_write ##1 !int_event_in |=> interrupt_n_out)
    else $error("forced interrupt not released");
  chk_nv_inhibit: assert property (nv_wr_req_in && s_q.ctrl[OTC_NV_WRITE_INHIBIT_BIT] |=> !nv_program_out)
    else $error("nonvolatile program during inhibit");
  chk_nv_working: assert property (nv_wr_req_in |=> nv_working_wr_out)
    else $error("working value write dropped");
  chk_nv_program: assert property (nv_wr_req_in && !s_q.ctrl[OTC_NV_WRITE_INHIBIT_BIT] |=> nv_program_out)
    else $error("nonvolatile program dropped");
  chk_dac_direct: assert property (s_q.ctrl[OTC_DAC_DIRECT_MODE_BIT] |=>
    bias_dac_out == $past(bias_dac_reg_in) && mod_dac_out == $past(mod_dac_reg_in))
    else $error("DAC not fed from register in direct mode");
  chk_dac_table: assert property (!s_q.ctrl[OTC_DAC_DIRECT_MODE_BIT] |=>
    bias_dac_out == $past(bias_dac_table_in) && mod_dac_out == $past(mod_dac_table_in))
    else $error("DAC not fed from lookup in normal mode");
  chk_force_txf: assert property (s_q.ctrl[OTC_FORCE_OUTPUTS_TEST_BIT] |=>
    transmit_fault_output_out == $past(tx_fault_active_high_in))
    else $error("transmit fault not forced to active level");
  chk_force_receive_loss_output: assert property (s_q.ctrl[OTC_FORCE_OUTPUTS_TEST_BIT] |=>
    receive_loss_output_out == $past(rx_loss_active_high_in))
    else $error("receive loss not forced to active level");
  chk_int_gate: assert property (!interrupt_n_out |->
    $past(global_interrupt_enable_in) && !$past(oem_interrupt_mask_in))
    else $error("interrupt asserted while gated off");
  chk_force_int: assert property (s_q.ctrl[OTC_FORCE_OUTPUTS_TEST_BIT] && global_interrupt_enable_in
    && !oem_interrupt_mask_in |=> !interrupt_n_out)
    else $error("forced interrupt not driven");
  // Refused reads must answer zero so a locked part leaks nothing
  chk_read_refused: assert property (reg_rd_in && !oem_pw_valid_in |=> reg_rdata_out == 8'h00)
    else $error("read answered without password");
  chk_read_data: assert property (s_valid_read |=> reg_rdata_out == $past(test_cal_out))
    else $error("read data not the stored register");
endmodule

// ==== verification/otc_host_model.sv ====
// Purpose: Host model that issues byte reads and writes to the control register
// Assumes: The block samples the strobes on the rising clock edge
// Notes: Address is inverted after each access and data after each write, so stale values never look valid
module otc_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Register access
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic pw_valid_out,
  input wire logic [7:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {reg_wr_out, reg_rd_out, pw_valid_out} = 3'h0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // One byte write; the strobe is high for one clock
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pw);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    pw_valid_out <= pw;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  // One byte read; data is taken after the edge that accepts the strobe
  task automatic rd(input logic [7:0] a, input logic pw, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    pw_valid_out <= pw;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    #1 d = reg_rdata_in;
  endtask
endmodule

// ==== verification/oem_test_calibration_control_test.sv ====
// Purpose: Self-checking bench for the test and calibration control register
// Assumes: Outputs settle one clock after the register write lands
// Notes: Fault waits cover more than two full comparator scans
module oem_test_calibration_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import otc_pkg::*;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, wr, rd, pw, mask, ie, txh, rxh, rxp, pin, ev, nvr, txf, intn, rxl, nvw, nvp;
  logic [1:0] sel;
  logic [2:0] cond, clr, flags;
  logic [7:0] addr, wd, rdat, br, bt, mr, mt, bo, mo, tc, d;
  int miscompares = 0, check_count = 0, cycles = 0;
  otc_host_model u_otc_host_model (.clk_sys_in(clk_sys_in), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wd), .pw_valid_out(pw), .reg_rdata_in(rdat));
  otc_ctrl u_otc_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wd), .oem_pw_valid_in(pw), .reg_rdata_out(rdat),
    .adc_spin_sel_in(sel), .oem_interrupt_mask_in(mask), .global_interrupt_enable_in(ie),
    .tx_fault_active_high_in(txh), .rx_loss_active_high_in(rxh), .rx_loss_from_pin_in(rxp),
    .fault_cond_in(cond), .fault_clear_in(clr), .int_event_in(ev), .rx_loss_pin_in(pin),
    .nv_wr_req_in(nvr), .nv_working_wr_out(nvw), .nv_program_out(nvp), .bias_dac_reg_in(br),
    .bias_dac_table_in(bt), .mod_dac_reg_in(mr), .mod_dac_table_in(mt), .bias_dac_out(bo),
    .mod_dac_out(mo), .transmit_fault_output_out(txf), .interrupt_n_out(intn),
    .receive_loss_output_out(rxl), .fault_flags_out(flags), .test_cal_out(tc));
  // Clock and hang guard
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Write of all writable bits, refused access without password
  task automatic t_access();
    check(tc, OTC_TEST_CAL_RESET);
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h79, 1'b1);
    u_otc_host_model.rd(OTC_TEST_CAL_ADDR, 1'b1, d);
    check(d, 8'h79);
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h00, 1'b0);
    u_otc_host_model.rd(OTC_TEST_CAL_ADDR, 1'b0, d);
    check(d, 8'h00);
    check(tc, 8'h79);
  endtask
  // Forced outputs under both polarities and the interrupt gates
  task automatic t_force();
    for (int p = 0; p < 2; p++) begin
      txh <= p[0];
      rxh <= p[0];
      rxp <= p[0];
      u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h01, 1'b1);
      tick(1);
      check({txf, rxl, intn}, {p[0], p[0], 1'b0});
    end
    mask <= 1'b1;
    tick(2);
    check(intn, 1'b1);
    mask <= 1'b0;
    ie <= 1'b0;
    tick(2);
    check(intn, 1'b1);
    ie <= 1'b1;
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h00, 1'b1);
    tick(1);
    check({txf, rxl, intn}, 3'h1);
    // Normal interrupt request, then the mask gate
    ev <= 1'b1;
    tick(2);
    check(intn, 1'b0);
    mask <= 1'b1;
    tick(2);
    check(intn, 1'b1);
    ev <= 1'b0;
    mask <= 1'b0;
    // Receive loss taken from the synchronised pin
    pin <= 1'b1;
    tick(6);
    check(rxl, 1'b1);
    pin <= 1'b0;
    tick(6);
    check(rxl, 1'b0);
  endtask
  // Write inhibit and direct DAC control
  task automatic t_nv_dac();
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h18, 1'b1);
    nvr <= 1'b1;
    @(posedge clk_sys_in);
    nvr <= 1'b0;
    #1 check({nvw, nvp}, 2'h2);
    check(bo, br);
    check(mo, mr);
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h00, 1'b1);
    nvr <= 1'b1;
    @(posedge clk_sys_in);
    nvr <= 1'b0;
    #1 check({nvw, nvp}, 2'h3);
    check(bo, bt);
    check(mo, mt);
  endtask
  // Comparator stop, sticky flags, single-channel hold
  task automatic t_fault();
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h40, 1'b1);
    cond <= 3'h7;
    tick(8);
    check(flags, 3'h0);
    cond <= 3'h1;
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h00, 1'b1);
    tick(8);
    check(flags, 3'h1);
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h40, 1'b1);
    cond <= 3'h7;
    tick(8);
    check(flags, 3'h1);
    cond <= 3'h0;
    clr <= 3'h7;
    tick(1);
    clr <= 3'h0;
    sel <= 2'h1;
    cond <= 3'h5;
    u_otc_host_model.wr(OTC_TEST_CAL_ADDR, 8'h20, 1'b1);
    tick(8);
    check(flags, 3'h0);
    cond <= 3'h2;
    tick(8);
    check(flags, 3'h2);
    // Held on the empty select code: no channel may respond
    cond <= 3'h0;
    sel <= 2'h3;
    clr <= 3'h7;
    tick(1);
    clr <= 3'h0;
    cond <= 3'h7;
    tick(8);
    check(flags, 3'h0);
  endtask
  // Main sequence
  initial begin
    {mask, pin, ev, nvr, rxp} = 5'h0;
    {ie, txh, rxh} = 3'h7;
    sel = 2'h0;
    {cond, clr} = 6'h00;
    {br, bt, mr, mt} = 32'h5aa5c33c;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    tick(1);
    check(intn, 1'b1);
    t_access();
    t_force();
    t_nv_dac();
    t_fault();
    conclude();
  end
endmodule
